// [hw/dtb_pkg.sv]
/*
 * Constants, mode codes and state type for the debug trigger and
 * breakpoint block.
 * Assumes a 16-bit CPU address bus and an 8-bit CPU data bus.
 */
package dtb_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int MODE_W = 4;
    localparam int COUNT_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int QUEUE_DEPTH = 3;
    localparam int QCNT_W = 2;
    localparam logic [COUNT_W-1:0] FIFO_FULL_COUNT = 4'h8;
    // ------------------------------------------------------------
    // Trigger mode field codes
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_A_ONLY = 4'h0;
    localparam logic [MODE_W-1:0] MODE_A_OR_B = 4'h1;
    localparam logic [MODE_W-1:0] MODE_A_THEN_B = 4'h2;
    localparam logic [MODE_W-1:0] MODE_EVENT_B = 4'h3;
    localparam logic [MODE_W-1:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [MODE_W-1:0] MODE_INSIDE = 4'h5;
    localparam logic [MODE_W-1:0] MODE_OUTSIDE = 4'h6;
    localparam logic [MODE_W-1:0] MODE_FULL_EQ = 4'h7;
    localparam logic [MODE_W-1:0] MODE_FULL_NE = 4'h8;
    // ------------------------------------------------------------
    // Background control byte layout and reset values
    // ------------------------------------------------------------
    localparam int CTRL_PERMIT_BIT = 7;
    localparam int CTRL_CLKSEL_BIT = 3;
    localparam logic PERMIT_RST = 1'b0;
    localparam logic CLKSEL_RST = 1'b0;
    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RUN_IDLE = 3'b001,
        RUN_WAIT = 3'b010,
        RUN_STORE = 3'b100
    } dtb_run_t;
endpackage : dtb_pkg

// [hw/dtb_opc_track.sv]
/*
 * Opcode tracker: follows match markers through the instruction queue.
 * Assumes fetch, execute and flush strobes from the CPU queue, same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dtb_opc_track (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic fetch_i,
    input wire logic tag_i,
    input wire logic exec_i,
    input wire logic flush_i,
    output logic hit_o
);
    logic [dtb_pkg::QUEUE_DEPTH-1:0] q_r;
    logic [dtb_pkg::QUEUE_DEPTH-1:0] q_nxt;
    logic [dtb_pkg::QCNT_W-1:0] n_r;
    logic [dtb_pkg::QCNT_W-1:0] n_nxt;

    // ------------------------------------------------------------
    // Queue of marker bits, head at bit 0
    // ------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        n_nxt = n_r;
        hit_o = 1'b0;
        if (exec_i && n_r != 2'h0) begin
            hit_o = q_r[0];
            q_nxt = q_r >> 1;
            n_nxt = n_r - 2'h1;
        end
        if (fetch_i && n_nxt < 2'(dtb_pkg::QUEUE_DEPTH)) begin
            q_nxt[n_nxt] = tag_i;
            n_nxt = n_nxt + 2'h1;
        end
        if (clr_i || flush_i) begin
            q_nxt = '0;
            n_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_r <= '0;
            n_r <= '0;
        end else begin
            q_r <= q_nxt;
            n_r <= n_nxt;
        end
    end
endmodule : dtb_opc_track
`default_nettype wire

// [hw/dtb_fifo.sv]
/*
 * Eight-word capture buffer with valid count, linear or circular fill.
 * Assumes the writer gives at most one word per clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dtb_fifo (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic wr_i,
    input wire logic circ_i,
    input wire logic [15:0] data_i,
    input wire logic [dtb_pkg::PTR_W-1:0] rd_idx_i,
    output logic [15:0] rd_data_o,
    output logic [dtb_pkg::COUNT_W-1:0] count_o,
    output logic full_o
);
    logic [15:0] mem [0:dtb_pkg::FIFO_DEPTH-1];
    logic [dtb_pkg::PTR_W-1:0] ptr_r;
    logic [dtb_pkg::PTR_W-1:0] ptr_nxt;
    logic [dtb_pkg::COUNT_W-1:0] cnt_r;
    logic [dtb_pkg::COUNT_W-1:0] cnt_nxt;
    logic [dtb_pkg::PTR_W-1:0] oldest;
    logic accept;

    // ------------------------------------------------------------
    // Pointer and count
    // ------------------------------------------------------------
    assign full_o = (cnt_r == dtb_pkg::FIFO_FULL_COUNT);
    assign accept = wr_i && (circ_i || !full_o) && !clr_i;
    assign count_o = cnt_r;

    always_comb begin
        ptr_nxt = ptr_r;
        cnt_nxt = cnt_r;
        if (clr_i) begin
            ptr_nxt = '0;
            cnt_nxt = '0;
        end else if (accept) begin
            ptr_nxt = ptr_r + 3'h1;
            if (!full_o) begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Storage and read port, index 0 is the oldest word
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (accept) begin
            mem[ptr_r] <= data_i;
        end
    end

    assign oldest = full_o ? ptr_r : 3'h0;
    assign rd_data_o = mem[3'(oldest + rd_idx_i)];
endmodule : dtb_fifo
`default_nettype wire

// [hw/dtb_trigger.sv]
/*
 * Debug trigger and breakpoint logic: comparators, trigger modes, run
 * control, capture buffer feed, CPU break requests, background control.
 * Assumes CPU bus, queue and host command strobes on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module dtb_trigger (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic bus_cycle_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] rdata_i,
    input wire logic [7:0] wdata_i,
    input wire logic rw_i,
    input wire logic bdc_access_i,
    input wire logic opcode_fetch_i,
    input wire logic opcode_exec_i,
    input wire logic queue_flush_i,
    input wire logic cof_valid_i,
    input wire logic [15:0] cof_addr_i,
    input wire logic debug_module_enable_i,
    input wire logic arm_wr_i,
    input wire logic arm_wr_val_i,
    input wire logic [3:0] trigger_mode_field_i,
    input wire logic opcode_qualify_select_i,
    input wire logic begin_trace_i,
    input wire logic cpu_break_enable_i,
    input wire logic tag_select_i,
    input wire logic dir_qualify_enable_a_i,
    input wire logic dir_value_a_i,
    input wire logic dir_qualify_enable_b_i,
    input wire logic dir_value_b_i,
    input wire logic [15:0] cmp_a_i,
    input wire logic [15:0] cmp_b_i,
    input wire logic break_ack_i,
    input wire logic [2:0] fifo_rd_idx_i,
    input wire logic ctrl_wr_i,
    input wire logic [7:0] ctrl_wr_data_i,
    input wire logic background_active_i,
    input wire logic wait_stop_i,
    input wire logic wait_stop_fail_i,
    input wire logic data_valid_fail_i,
    output logic run_active_flag_o,
    output logic comparator_a_hit_flag_o,
    output logic comparator_b_hit_flag_o,
    output logic [3:0] fifo_valid_count_o,
    output logic [15:0] fifo_rd_data_o,
    output logic tag_mark_o,
    output logic force_break_o,
    output logic break_use_swi_o,
    output logic [7:0] background_ctrl_status_reg_o
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    logic run_r;
    logic bus_qual;
    logic dir_ok_a;
    logic dir_ok_b;
    logic raw_a;
    logic raw_b;
    logic data_eq;
    logic [7:0] dsel;
    logic cond_a;
    logic is_event;
    logic is_full;
    logic arm_start;
    logic run_stop;

    assign arm_start = arm_wr_i && arm_wr_val_i && debug_module_enable_i;
    assign run_stop = (arm_wr_i && !arm_wr_val_i) || !debug_module_enable_i;
    assign bus_qual = bus_cycle_i && debug_module_enable_i && run_r
        && !bdc_access_i;
    assign dir_ok_a = !dir_qualify_enable_a_i || (rw_i == dir_value_a_i);
    assign dir_ok_b = !dir_qualify_enable_b_i || (rw_i == dir_value_b_i);
    assign raw_a = (addr_i == cmp_a_i) && dir_ok_a;
    assign raw_b = (addr_i == cmp_b_i) && dir_ok_b;
    assign dsel = (dir_qualify_enable_a_i && !dir_value_a_i) ? wdata_i : rdata_i;
    assign data_eq = (dsel == cmp_b_i[7:0]);
    assign is_event = (trigger_mode_field_i == dtb_pkg::MODE_EVENT_B)
        || (trigger_mode_field_i == dtb_pkg::MODE_A_THEN_EVENT_B);
    assign is_full = (trigger_mode_field_i == dtb_pkg::MODE_FULL_EQ)
        || (trigger_mode_field_i == dtb_pkg::MODE_FULL_NE);

    always_comb begin
        unique case (trigger_mode_field_i)
            dtb_pkg::MODE_INSIDE: cond_a = (addr_i >= cmp_a_i) && (addr_i <= cmp_b_i)
                && dir_ok_a;
            dtb_pkg::MODE_OUTSIDE: cond_a = ((addr_i < cmp_a_i) || (addr_i > cmp_b_i))
                && dir_ok_a;
            dtb_pkg::MODE_FULL_EQ: cond_a = raw_a && data_eq;
            dtb_pkg::MODE_FULL_NE: cond_a = raw_a && !data_eq;
            default: cond_a = raw_a;
        endcase
    end

    // ------------------------------------------------------------
    // Opcode tracking
    // ------------------------------------------------------------
    logic trk_a_hit;
    logic trk_b_hit;
    logic trk_fetch;
    logic trk_exec;

    assign trk_fetch = bus_qual && opcode_fetch_i;
    assign trk_exec = opcode_exec_i && run_r && debug_module_enable_i;

    dtb_opc_track u_trk_a (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .clr_i(arm_start),
        .fetch_i(trk_fetch),
        .tag_i(cond_a),
        .exec_i(trk_exec),
        .flush_i(queue_flush_i),
        .hit_o(trk_a_hit)
    );

    dtb_opc_track u_trk_b (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .clr_i(arm_start),
        .fetch_i(trk_fetch),
        .tag_i(raw_b),
        .exec_i(trk_exec),
        .flush_i(queue_flush_i),
        .hit_o(trk_b_hit)
    );

    // ------------------------------------------------------------
    // Trigger mode selection
    // ------------------------------------------------------------
    logic qa;
    logic qb;
    logic trig;
    logic raw_trig;
    logic a_flag_r;
    logic b_flag_r;

    assign qa = opcode_qualify_select_i ? trk_a_hit : (bus_qual && cond_a);
    assign qb = opcode_qualify_select_i ? trk_b_hit : (bus_qual && raw_b);

    always_comb begin
        unique case (trigger_mode_field_i)
            dtb_pkg::MODE_A_ONLY, dtb_pkg::MODE_INSIDE, dtb_pkg::MODE_OUTSIDE,
            dtb_pkg::MODE_FULL_EQ, dtb_pkg::MODE_FULL_NE: begin
                trig = qa;
                raw_trig = is_full ? raw_a : cond_a;
            end
            dtb_pkg::MODE_A_OR_B: begin
                trig = qa || qb;
                raw_trig = cond_a || raw_b;
            end
            dtb_pkg::MODE_A_THEN_B, dtb_pkg::MODE_A_THEN_EVENT_B: begin
                trig = qb && a_flag_r;
                raw_trig = raw_b && a_flag_r;
            end
            dtb_pkg::MODE_EVENT_B: begin
                trig = qb;
                raw_trig = raw_b;
            end
            default: begin
                trig = 1'b0;
                raw_trig = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    dtb_pkg::dtb_run_t state_r;
    dtb_pkg::dtb_run_t state_nxt;
    logic begin_eff;
    logic fifo_full;
    logic fifo_wr;
    logic [15:0] fifo_din;
    logic [15:0] fifo_rd;
    logic [3:0] fifo_cnt;
    logic a_flag_nxt;
    logic b_flag_nxt;

    assign begin_eff = begin_trace_i || is_event;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dtb_pkg::RUN_IDLE: state_nxt = dtb_pkg::RUN_IDLE;
            dtb_pkg::RUN_WAIT: begin
                if (trig) begin
                    state_nxt = dtb_pkg::RUN_STORE;
                end
            end
            dtb_pkg::RUN_STORE: begin
                if (begin_eff ? fifo_full : trig) begin
                    state_nxt = dtb_pkg::RUN_IDLE;
                end
            end
        endcase
        if (arm_start) begin
            state_nxt = (begin_eff && !is_event) ? dtb_pkg::RUN_WAIT
                : dtb_pkg::RUN_STORE;
        end else if (run_stop) begin
            state_nxt = dtb_pkg::RUN_IDLE;
        end
        a_flag_nxt = (a_flag_r && !arm_start) || qa;
        b_flag_nxt = (b_flag_r && !arm_start) || qb;
    end

    assign fifo_wr = (state_r == dtb_pkg::RUN_STORE) && (is_event ? trig : cof_valid_i);
    assign fifo_din = is_event ? {8'h00, dsel} : cof_addr_i;

    dtb_fifo u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .clr_i(arm_start),
        .wr_i(fifo_wr),
        .circ_i(!begin_eff),
        .data_i(fifo_din),
        .rd_idx_i(fifo_rd_idx_i),
        .rd_data_o(fifo_rd),
        .count_o(fifo_cnt),
        .full_o(fifo_full)
    );

    // ------------------------------------------------------------
    // Break requests and background control
    // ------------------------------------------------------------
    logic tag_nxt;
    logic force_nxt;
    logic permit_r;
    logic permit_nxt;
    logic clksel_r;
    logic clksel_nxt;
    logic [3:0] stat_r;

    always_comb begin
        tag_nxt = cpu_break_enable_i && tag_select_i && trk_fetch && raw_trig;
        force_nxt = (force_break_o && !break_ack_i)
            || (cpu_break_enable_i && !tag_select_i && trig);
        permit_nxt = permit_r;
        clksel_nxt = clksel_r;
        if (ctrl_wr_i && !background_active_i) begin
            permit_nxt = ctrl_wr_data_i[dtb_pkg::CTRL_PERMIT_BIT];
        end
        if (ctrl_wr_i) begin
            clksel_nxt = ctrl_wr_data_i[dtb_pkg::CTRL_CLKSEL_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= dtb_pkg::RUN_IDLE;
            run_r <= 1'b0;
            a_flag_r <= 1'b0;
            b_flag_r <= 1'b0;
            permit_r <= dtb_pkg::PERMIT_RST;
            clksel_r <= dtb_pkg::CLKSEL_RST;
            stat_r <= '0;
            run_active_flag_o <= 1'b0;
            comparator_a_hit_flag_o <= 1'b0;
            comparator_b_hit_flag_o <= 1'b0;
            fifo_valid_count_o <= '0;
            fifo_rd_data_o <= '0;
            tag_mark_o <= 1'b0;
            force_break_o <= 1'b0;
            break_use_swi_o <= 1'b1;
            background_ctrl_status_reg_o <= '0;
        end else begin
            state_r <= state_nxt;
            run_r <= (state_nxt != dtb_pkg::RUN_IDLE);
            a_flag_r <= a_flag_nxt;
            b_flag_r <= b_flag_nxt;
            permit_r <= permit_nxt;
            clksel_r <= clksel_nxt;
            stat_r <= {background_active_i, wait_stop_i, wait_stop_fail_i, data_valid_fail_i};
            run_active_flag_o <= (state_nxt != dtb_pkg::RUN_IDLE);
            comparator_a_hit_flag_o <= a_flag_nxt;
            comparator_b_hit_flag_o <= b_flag_nxt;
            fifo_valid_count_o <= fifo_cnt;
            fifo_rd_data_o <= fifo_rd;
            tag_mark_o <= tag_nxt;
            force_break_o <= force_nxt;
            break_use_swi_o <= !permit_nxt;
            background_ctrl_status_reg_o <= {permit_nxt, stat_r[3], 2'b00, clksel_nxt,
                stat_r[2:0]};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    arm_clears_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        arm_start && !run_r |=> run_active_flag_o && !comparator_a_hit_flag_o
            && !comparator_b_hit_flag_o ##1 fifo_valid_count_o == 4'h0)
        else $error("Arm did not start a clean run");
    stop_now_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        run_stop && !arm_start |=> !run_active_flag_o)
        else $error("Run not stopped by disarm or disable");
    begin_full_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        state_r == dtb_pkg::RUN_STORE && begin_eff && fifo_full && !arm_start
            |=> !run_active_flag_o)
        else $error("Begin run did not end on full buffer");
    force_hold_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        force_break_o && !break_ack_i |=> force_break_o)
        else $error("Force request dropped before acknowledge");
    permit_lock_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        background_active_i |=> background_ctrl_status_reg_o[7] == $past(permit_r))
        else $error("Permit changed during background mode");
    bdc_quiet_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        bdc_access_i && !opcode_qualify_select_i && !arm_start
            |=> comparator_a_hit_flag_o == $past(a_flag_r))
        else $error("Comparator matched during controller access");
    full_tag_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        is_full && cpu_break_enable_i && tag_select_i && trk_fetch && raw_a
            |=> tag_mark_o)
        else $error("Full mode tag request missing on address match");
    range_in_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        trigger_mode_field_i == dtb_pkg::MODE_INSIDE && !opcode_qualify_select_i
            && bus_qual && dir_ok_a && addr_i >= cmp_a_i && addr_i <= cmp_b_i
            |=> comparator_a_hit_flag_o)
        else $error("Inside range match not flagged");
    event_store_a:
    assert property (@(posedge clk_i) disable iff (!rst_n)
        trigger_mode_field_i == dtb_pkg::MODE_EVENT_B && state_r == dtb_pkg::RUN_STORE
            && qb && !fifo_full && !arm_start
            |=> ##1 fifo_valid_count_o == $past(fifo_cnt, 2) + 4'h1)
        else $error("Event data not captured");
endmodule : dtb_trigger
`default_nettype wire

// [bench/dtb_cpu_model.sv]
/*
 * CPU core stand-in: takes a force break once the running instruction ends.
 * Assumes the force request comes from the trigger block on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dtb_cpu_model #(
    parameter int ACK_DLY = 4
) (
    input wire logic clk_i,
    input wire logic force_i,
    output logic ack_o
);
    int cnt = 0;
    initial ack_o = 1'b0;
    // Instruction ends ACK_DLY cycles after the request, then one ack pulse
    always @(posedge clk_i) begin
        if (force_i && !ack_o && cnt == ACK_DLY - 1) begin
            ack_o <= 1'b1;
            cnt <= 0;
        end else begin
            ack_o <= 1'b0;
            cnt <= (force_i && !ack_o) ? cnt + 1 : 0;
        end
    end
endmodule : dtb_cpu_model
`default_nettype wire

// [bench/dtb_trigger_test.sv]
/*
 * Self-checking bench for dtb_trigger, inputs driven at the falling edge.
 * Assumes dtb_cpu_model stands in for the CPU core.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module dtb_trigger_test;
    logic clk_i = 0, arst_n_i = 0, bus_cycle_i = 0, rw_i = 1, bdc_access_i = 0, st = 0;
    logic opcode_fetch_i = 0, opcode_exec_i = 0, queue_flush_i = 0, cof_valid_i = 0;
    logic debug_module_enable_i = 1, arm_wr_i = 0, arm_wr_val_i = 0, tag_select_i = 0;
    logic opcode_qualify_select_i = 0, begin_trace_i = 1, cpu_break_enable_i = 1;
    logic dir_qualify_enable_a_i = 0, dir_value_a_i = 0, dir_qualify_enable_b_i = 0;
    logic dir_value_b_i = 0, ctrl_wr_i = 0, background_active_i = 0, break_ack_i;
    logic run_active_flag_o, comparator_a_hit_flag_o, comparator_b_hit_flag_o, tag_mark_o;
    logic force_break_o, break_use_swi_o;
    logic [15:0] addr_i = 0, cof_addr_i = 0, cmp_a_i = 16'h1000, cmp_b_i = 16'h1010;
    logic [15:0] fifo_rd_data_o;
    logic [7:0] rdata_i = 0, wdata_i = 0, ctrl_wr_data_i = 0, background_ctrl_status_reg_o;
    logic [3:0] trigger_mode_field_i = 0, fifo_valid_count_o;
    logic [2:0] fifo_rd_idx_i = 0;
    int miscompares = 0, cmp_count = 0;
    dtb_trigger dut_u (.clk_i, .arst_n_i, .bus_cycle_i, .addr_i, .rdata_i, .wdata_i, .rw_i,
        .bdc_access_i, .opcode_fetch_i, .opcode_exec_i, .queue_flush_i, .cof_valid_i,
        .cof_addr_i, .debug_module_enable_i, .arm_wr_i, .arm_wr_val_i, .trigger_mode_field_i,
        .opcode_qualify_select_i, .begin_trace_i, .cpu_break_enable_i, .tag_select_i,
        .dir_qualify_enable_a_i, .dir_value_a_i, .dir_qualify_enable_b_i, .dir_value_b_i,
        .cmp_a_i, .cmp_b_i, .break_ack_i, .fifo_rd_idx_i, .ctrl_wr_i, .ctrl_wr_data_i,
        .background_active_i, .wait_stop_i(st), .wait_stop_fail_i(st), .data_valid_fail_i(st),
        .run_active_flag_o, .comparator_a_hit_flag_o, .comparator_b_hit_flag_o,
        .fifo_valid_count_o, .fifo_rd_data_o, .tag_mark_o, .force_break_o, .break_use_swi_o,
        .background_ctrl_status_reg_o);
    dtb_cpu_model #(.ACK_DLY(4)) cpu_u (.clk_i, .force_i(force_break_o), .ack_o(break_ack_i));
    initial forever #4 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task automatic idle(input int n);
        {bus_cycle_i, bdc_access_i, opcode_fetch_i, opcode_exec_i, queue_flush_i} = 5'h00;
        tick(n);
    endtask : idle
    task automatic bus(input logic [15:0] a, input logic [15:0] d, input logic r, input logic b);
        {bus_cycle_i, bdc_access_i, rw_i, addr_i, rdata_i, wdata_i} = {1'b1, b, r, a, d};
        tick(1);
    endtask : bus
    task automatic arm(input logic v);
        {arm_wr_i, arm_wr_val_i} = {1'b1, v};
        tick(1);
        arm_wr_i = 1'b0;
    endtask : arm
    task automatic ctrl(input logic [7:0] d);
        {ctrl_wr_i, ctrl_wr_data_i} = {1'b1, d};
        tick(1);
        ctrl_wr_i = 1'b0;
        tick(1);
    endtask : ctrl
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // Row: mode, first addr, second addr, {rdata, wdata}, {rw, dir en, dir val, bdc}, force
    task automatic row(input logic [59:0] r);
        {trigger_mode_field_i, dir_qualify_enable_a_i, dir_value_a_i} = {r[59:56], r[6:5]};
        arm(1'b1);
        bus(r[55:40], 16'h0000, 1'b1, 1'b0);
        bus(r[39:24], r[23:8], r[7], r[4]);
        idle(2);
        `CHK("force_break_o", r[0], force_break_o)
        for (int i = 0; i < 20 && force_break_o !== 1'b0; i++) tick(1);
        if (force_break_o !== 1'b0) begin
            miscompares++;
            conclude();
        end
    endtask : row
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        tick(2);
        arst_n_i = 1'b1;
        tick(3);
        `CHK("swi", 1'b1, break_use_swi_o)
        {background_active_i, st} = 2'b11;
        ctrl(8'hff);
        `CHK("status", 8'h4f, background_ctrl_status_reg_o)
        {background_active_i, st} = 2'b00;
        ctrl(8'h80);
        `CHK("status", 8'h80, background_ctrl_status_reg_o)
        `CHK("swi", 1'b0, break_use_swi_o)
        done("control");
        row(60'h0_3000_1010_0000_8_0);
        row(60'h0_3000_1000_0000_8_1);
        row(60'h0_3000_1000_0000_9_0);
        row(60'h0_3000_1000_0000_c_0);
        row(60'h0_3000_1000_0000_e_1);
        row(60'h1_3000_2000_0000_8_0);
        row(60'h1_3000_1010_0000_8_1);
        {dir_qualify_enable_b_i, dir_value_b_i} = 2'b10;
        row(60'h1_3000_1010_0000_8_0);
        {dir_qualify_enable_b_i, dir_value_b_i} = 2'b00;
        row(60'h2_3000_1010_0000_8_0);
        row(60'h2_1000_1010_0000_8_1);
        row(60'h3_3000_1000_0000_8_0);
        row(60'h3_3000_1010_0000_8_1);
        row(60'h4_3000_1010_0000_8_0);
        row(60'h4_1000_1010_0000_8_1);
        row(60'h5_3000_0fff_0000_8_0);
        row(60'h5_3000_1010_0000_8_1);
        row(60'h6_1005_1000_0000_8_0);
        row(60'h6_1005_1011_0000_8_1);
        row(60'h7_3000_1000_1100_8_0);
        row(60'h7_3000_1000_1000_8_1);
        row(60'h7_3000_1000_1011_4_0);
        row(60'h7_3000_1000_1110_4_1);
        row(60'h8_3000_1000_1000_8_0);
        row(60'h8_3000_1000_1100_8_1);
        row(60'h9_1000_1010_0000_8_0);
        done("modes");
        {cpu_break_enable_i, opcode_qualify_select_i, trigger_mode_field_i} = 6'h10;
        arm(1'b1);
        opcode_fetch_i = 1'b1;
        bus(16'h1000, 16'h0000, 1'b1, 1'b0);
        {bus_cycle_i, opcode_fetch_i, queue_flush_i} = 3'b001;
        tick(1);
        idle(2);
        `CHK("a_hit", 1'b0, comparator_a_hit_flag_o)
        opcode_fetch_i = 1'b1;
        bus(16'h1000, 16'h0000, 1'b1, 1'b0);
        {bus_cycle_i, opcode_fetch_i, opcode_exec_i} = 3'b001;
        tick(1);
        idle(2);
        `CHK("a_hit", 1'b1, comparator_a_hit_flag_o)
        {cpu_break_enable_i, tag_select_i, opcode_qualify_select_i} = 3'b110;
        trigger_mode_field_i = 4'h7;
        arm(1'b1);
        opcode_fetch_i = 1'b1;
        bus(16'h1000, 16'h1100, 1'b1, 1'b0);
        `CHK("tag_mark", 1'b1, tag_mark_o)
        idle(1);
        `CHK("tag_mark", 1'b0, tag_mark_o)
        done("tag");
        {cpu_break_enable_i, tag_select_i, begin_trace_i, trigger_mode_field_i} = 7'h03;
        arm(1'b1);
        for (int i = 0; i < 9; i++) bus(16'h1010, {8'ha0 + 8'(i), 8'h00}, 1'b1, 1'b0);
        idle(3);
        `CHK("count", 4'h8, fifo_valid_count_o)
        `CHK("b_hit", 1'b1, comparator_b_hit_flag_o)
        `CHK("run", 1'b0, run_active_flag_o)
        fifo_rd_idx_i = 3'h7;
        tick(2);
        `CHK("fifo_word", 16'h00a7, fifo_rd_data_o)
        arm(1'b1);
        `CHK("run", 1'b1, run_active_flag_o)
        `CHK("b_hit", 1'b0, comparator_b_hit_flag_o)
        tick(1);
        `CHK("count", 4'h0, fifo_valid_count_o)
        arm(1'b0);
        `CHK("run", 1'b0, run_active_flag_o)
        tick(1);
        arm(1'b1);
        debug_module_enable_i = 1'b0;
        tick(1);
        `CHK("run", 1'b0, run_active_flag_o)
        arm(1'b1);
        `CHK("run", 1'b0, run_active_flag_o)
        tick(1);
        {debug_module_enable_i, trigger_mode_field_i} = 5'h10;
        arm(1'b1);
        bus(16'h1000, 16'h0000, 1'b1, 1'b0);
        idle(2);
        `CHK("run", 1'b0, run_active_flag_o)
        begin_trace_i = 1'b1;
        arm(1'b1);
        bus(16'h1000, 16'h0000, 1'b1, 1'b0);
        idle(2);
        `CHK("run", 1'b1, run_active_flag_o)
        {begin_trace_i, fifo_rd_idx_i} = 4'h0;
        arm(1'b1);
        for (int i = 0; i < 10; i++) begin
            {cof_valid_i, cof_addr_i} = {1'b1, 16'h2000 + 16'(i)};
            tick(1);
        end
        cof_valid_i = 1'b0;
        bus(16'h1000, 16'h0000, 1'b1, 1'b0);
        idle(2);
        `CHK("run", 1'b0, run_active_flag_o)
        `CHK("count", 4'h8, fifo_valid_count_o)
        `CHK("fifo_word", 16'h2002, fifo_rd_data_o)
        done("run");
        conclude();
    end
endmodule : dtb_trigger_test
`default_nettype wire
